// ### vem_consts.svh
`ifndef VEM_CONSTS_SVH
`define VEM_CONSTS_SVH

// ==========================================
// register map
`define VEM_OFS_DAC_POWER 7'h01
`define VEM_OFS_ROUTING 7'h02
`define VEM_OFS_TELETEXT 7'h03
`define VEM_OFS_SYNC_GENLOCK 7'h04
`define VEM_OFS_LEVEL_CLAMP 7'h05
`define VEM_OFS_POWERUP_PLL 7'h06
`define VEM_OFS_FIRST `VEM_OFS_DAC_POWER
`define VEM_OFS_LAST `VEM_OFS_POWERUP_PLL

// ==========================================
// writable bits per register
`define VEM_WMASK_DAC_POWER 8'h7F
`define VEM_WMASK_ROUTING 8'hFF
`define VEM_WMASK_TELETEXT 8'h7C
`define VEM_WMASK_SYNC_GENLOCK 8'hFF
`define VEM_WMASK_LEVEL_CLAMP 8'hFF
`define VEM_WMASK_POWERUP_PLL 8'h03

// ==========================================
// reset values
`define VEM_RST_MODE 8'h00
`define VEM_RST_POWERUP_PLL 8'h01

// ==========================================
// field positions
`define VEM_BIT_OVERSAMPLE 6
`define VEM_BIT_YUV 0
`define VEM_BIT_GROUP 1
`define VEM_BIT_SCART 2
`define VEM_BIT_PEDESTAL 3
`define VEM_BIT_SQUARE 4
`define VEM_BIT_STD_SRC 5
`define VEM_BIT_PIXEL_VALID 6
`define VEM_BIT_SLEEP 7
`define VEM_REV_LSB 0
`define VEM_BIT_VBI_OPEN 2
`define VEM_BIT_TTX_EN 3
`define VEM_BIT_TTX_MODE 4
`define VEM_CC_LSB 5
`define VEM_BIT_VSYNC3 0
`define VEM_BIT_GL_LO 1
`define VEM_BIT_GL_HI 2
`define VEM_BIT_ACTIVE_LINE 3
`define VEM_BIT_CHROMA 4
`define VEM_BIT_BURST 5
`define VEM_BIT_BARS 6
`define VEM_BIT_INTERLACE 7
`define VEM_BIT_Y_LEVEL 0
`define VEM_UV_LSB 1
`define VEM_BIT_RGB_SYNC 3
`define VEM_CLAMP_LSB 4
`define VEM_BIT_CLAMP_DIR 6
`define VEM_BIT_CLAMP_POS 7
`define VEM_BIT_PU_SLEEP 0
`define VEM_BIT_PLL_N 1
`define VEM_FIELD_LSB 5

// ==========================================
// values and timing
`define VEM_REVISION 2'h0
`define VEM_SLAVE_ADDR 7'h2A
`define VEM_ALSB_BIT 1
`define VEM_RATE_4X_MHZ 6'h36
`define VEM_RATE_2X_MHZ 6'h1B
`define VEM_PIX_601 10'h2D0
`define VEM_PIX_NTSC_470 10'h2C6
`define VEM_PIX_PAL_470 10'h2BE
`define VEM_UV_700 10'h2BC
`define VEM_UV_1000 10'h3E8
`define VEM_UV_NTSC_DEF 10'h3A6
`define VEM_VSYNC_PAL_HALF 3'h5
`define VEM_VSYNC_NTSC_HALF 3'h6
`define VEM_FIELD_MAX_NTSC 3'h3
`define VEM_FIELD_MAX_PAL 3'h7
`define VEM_TR_MIN_NS 37
`define VEM_CLK_NS 25
`define VEM_TR_MIN_CYC ((`VEM_TR_MIN_NS + `VEM_CLK_NS - 1) / `VEM_CLK_NS)

`endif

// ### vem_pkg.sv
package vem_pkg;

   typedef enum logic [3:0] {
      VEM_SRC_CVBS, VEM_SRC_LUMA, VEM_SRC_CHROMA,
      VEM_SRC_G, VEM_SRC_B, VEM_SRC_R,
      VEM_SRC_Y, VEM_SRC_U, VEM_SRC_V
   } vem_dac_src_e;

   typedef enum logic [2:0] {
      VEM_ST_IDLE, VEM_ST_DEVADDR, VEM_ST_SUBADDR, VEM_ST_WRITE, VEM_ST_READ
   } vem_bus_state_e;

   typedef struct packed {
      logic [5:0] dacPowerDown;
      logic dacRate4x;
      logic [5:0] dacRateMhz;
      logic pllEnable;
      vem_dac_src_e [5:0] dacSrc;
      logic pedestalEn;
      logic squarePixelEn;
      logic palActive;
      logic pixelBlank;
      logic forceMaster;
      logic sleep;
      logic teletextEn;
      logic ttxRequest;
      logic vbiOpen;
      logic [1:0] ccField;
      logic [2:0] vsyncHalfLines;
      logic countersHeld;
      logic rtcEnable;
      logic [9:0] activePixels;
      logic chromaEn;
      logic burstEn;
      logic colourBars;
      logic syncOutEnN;
      logic interlaceOff;
      logic ySmpte;
      logic [9:0] uvLevelMv;
      logic rgbSync;
      logic [1:0] clampDelay;
      logic clampNegative;
      logic clampBackPorch;
      logic [2:0] fieldCount;
   } vem_video_ctrl_s;

endpackage : vem_pkg

// ### vem_mode_regs.sv
`include "vem_consts.svh"

module vem_mode_regs
   import vem_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOeN,
   input wire logic alsbPin,
   input wire logic standardPin,
   input wire logic resetControlPin,
   input wire logic programmedPal,
   input wire logic ttxBitRequest,
   input wire logic fieldStart,
   output vem_video_ctrl_s videoCtrl,
   output logic pllReset,
   output logic scPhaseReset
);

   // ==========================================
   // helpers
   function automatic logic offsetValid(input logic [6:0] ofs);
      offsetValid = (ofs >= `VEM_OFS_FIRST) && (ofs <= `VEM_OFS_LAST);
   endfunction : offsetValid

   function automatic logic [7:0] writeMask(input logic [6:0] ofs);
      case (ofs)
         `VEM_OFS_DAC_POWER: writeMask = `VEM_WMASK_DAC_POWER;
         `VEM_OFS_ROUTING: writeMask = `VEM_WMASK_ROUTING;
         `VEM_OFS_TELETEXT: writeMask = `VEM_WMASK_TELETEXT;
         `VEM_OFS_SYNC_GENLOCK: writeMask = `VEM_WMASK_SYNC_GENLOCK;
         `VEM_OFS_LEVEL_CLAMP: writeMask = `VEM_WMASK_LEVEL_CLAMP;
         `VEM_OFS_POWERUP_PLL: writeMask = `VEM_WMASK_POWERUP_PLL;
         default: writeMask = 8'h00;
      endcase
   endfunction : writeMask

   function automatic vem_dac_src_e [5:0] dacRoute(input logic scart, input logic grp,
                                                  input logic yuv);
      vem_dac_src_e c0;
      vem_dac_src_e c1;
      vem_dac_src_e c2;
      c0 = yuv ? VEM_SRC_Y : VEM_SRC_G;
      c1 = yuv ? VEM_SRC_U : VEM_SRC_B;
      c2 = yuv ? VEM_SRC_V : VEM_SRC_R;
      if (grp) begin
         dacRoute = {c2, c1, c0, VEM_SRC_CHROMA, VEM_SRC_LUMA, VEM_SRC_CVBS};
      end else if (!scart) begin
         dacRoute = {VEM_SRC_CHROMA, VEM_SRC_LUMA, VEM_SRC_CVBS, c2, c1, c0};
      end else begin
         dacRoute = {VEM_SRC_CHROMA, VEM_SRC_LUMA, c0, c2, c1, VEM_SRC_CVBS};
      end
   endfunction : dacRoute

   // ==========================================
   // bus front end
   logic sclPrev_reg;
   logic sdaPrev_reg;
   vem_bus_state_e state_reg;
   logic [3:0] bitCnt_reg;
   logic [7:0] shift_reg;
   logic [6:0] ptr_reg;
   logic ackPhase_reg;
   logic masterNack_reg;
   logic sdaOeN_reg;
   logic sdaOut_reg;
   logic [7:0] modeReg_reg [1:6];
   logic [2:0] fieldCnt_reg;

   wire sclRise = scl & ~sclPrev_reg;
   wire sclFall = ~scl & sclPrev_reg;
   wire startCond = scl & sclPrev_reg & sdaPrev_reg & ~sdaIn;
   wire stopCond = scl & sclPrev_reg & ~sdaPrev_reg & sdaIn;
   wire byteDone = sclFall & ~ackPhase_reg & (bitCnt_reg == 4'h8) & ~startCond & ~stopCond;
   wire ackEnd = sclFall & ackPhase_reg & ~startCond & ~stopCond;
   wire [6:0] ownAddr = (`VEM_SLAVE_ADDR & ~(7'h01 << `VEM_ALSB_BIT))
                        | ({6'h00, alsbPin} << `VEM_ALSB_BIT);
   wire addrMatch = (shift_reg[7:1] == ownAddr);
   wire ptrValid = offsetValid(ptr_reg);
   wire subValid = offsetValid(shift_reg[6:0]);
   wire wrEn = byteDone & (state_reg == VEM_ST_WRITE) & ptrValid;
   wire [7:0] wrMasked = shift_reg & writeMask(ptr_reg);
   wire [2:0] ptrIdx = ptr_reg[2:0];

   // ==========================================
   // read data
   wire [7:0] mr1 = modeReg_reg[1];
   wire [7:0] mr2 = modeReg_reg[2];
   wire [7:0] mr3 = modeReg_reg[3];
   wire [7:0] mr4 = modeReg_reg[4];
   wire [7:0] mr5 = modeReg_reg[5];
   wire [7:0] mr6 = modeReg_reg[6];
   wire [7:0] rdTeletext = mr3 | {6'h00, `VEM_REVISION};
   wire [7:0] rdPowerUp = {fieldCnt_reg, mr6[4:0]};
   wire [7:0] rdValue = !ptrValid ? 8'h00 :
                        (ptr_reg == `VEM_OFS_TELETEXT) ? rdTeletext :
                        (ptr_reg == `VEM_OFS_POWERUP_PLL) ? rdPowerUp :
                        modeReg_reg[ptrIdx];
   wire [6:0] ptrRdNext = (ptr_reg >= `VEM_OFS_LAST) ? ptr_reg : ptr_reg + 7'h01;

   // ==========================================
   // serial slave state machine
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclPrev_reg <= 1'b1;
         sdaPrev_reg <= 1'b1;
      end else begin
         sclPrev_reg <= scl;
         sdaPrev_reg <= sdaIn;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= VEM_ST_IDLE;
         bitCnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         ptr_reg <= 7'h00;
         ackPhase_reg <= 1'b0;
         masterNack_reg <= 1'b0;
         sdaOeN_reg <= 1'b1;
         sdaOut_reg <= 1'b0;
      end else if (startCond) begin
         state_reg <= VEM_ST_DEVADDR;
         bitCnt_reg <= 4'h0;
         ackPhase_reg <= 1'b0;
         sdaOeN_reg <= 1'b1;
      end else if (stopCond) begin
         state_reg <= VEM_ST_IDLE;
         ackPhase_reg <= 1'b0;
         sdaOeN_reg <= 1'b1;
      end else if (sclRise && state_reg != VEM_ST_IDLE) begin
         if (ackPhase_reg) begin
            masterNack_reg <= sdaIn;
         end else begin
            bitCnt_reg <= bitCnt_reg + 4'h1;
            if (state_reg != VEM_ST_READ) begin
               shift_reg <= {shift_reg[6:0], sdaIn};
            end
         end
      end else if (byteDone) begin
         ackPhase_reg <= 1'b1;
         case (state_reg)
            VEM_ST_DEVADDR: begin
               sdaOeN_reg <= ~addrMatch;
               masterNack_reg <= 1'b0;
               if (!addrMatch) begin
                  state_reg <= VEM_ST_IDLE;
               end else if (shift_reg[0]) begin
                  state_reg <= VEM_ST_READ;
               end else begin
                  state_reg <= VEM_ST_SUBADDR;
               end
            end
            VEM_ST_SUBADDR: begin
               sdaOeN_reg <= ~subValid;
               ptr_reg <= shift_reg[6:0];
               state_reg <= subValid ? VEM_ST_WRITE : VEM_ST_IDLE;
            end
            VEM_ST_WRITE: begin
               sdaOeN_reg <= ~ptrValid;
               ptr_reg <= ptr_reg + 7'h01;
               if (!ptrValid) begin
                  state_reg <= VEM_ST_IDLE;
               end
            end
            default: begin
               sdaOeN_reg <= 1'b1;
            end
         endcase
      end else if (ackEnd) begin
         ackPhase_reg <= 1'b0;
         bitCnt_reg <= 4'h0;
         sdaOeN_reg <= 1'b1;
         if (state_reg == VEM_ST_READ) begin
            if (masterNack_reg) begin
               state_reg <= VEM_ST_IDLE;
            end else begin
               shift_reg <= rdValue;
               sdaOeN_reg <= rdValue[7];
               ptr_reg <= ptrRdNext;
            end
         end
      end else if (sclFall && state_reg == VEM_ST_READ && !ackPhase_reg
                   && bitCnt_reg != 4'h0 && bitCnt_reg != 4'h8) begin
         sdaOeN_reg <= shift_reg[6];
         shift_reg <= {shift_reg[6:0], 1'b0};
      end
   end

   // ==========================================
   // register storage
   logic puInit_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         puInit_reg <= 1'b1;
      end else begin
         puInit_reg <= 1'b0;
      end
   end

   generate
      for (genvar i = 1; i <= 6; i++) begin : g_mode
         localparam logic [6:0] OFS = 7'(i);
         localparam logic [7:0] RST_VAL = (OFS == `VEM_OFS_POWERUP_PLL)
                                          ? `VEM_RST_POWERUP_PLL : `VEM_RST_MODE;
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               modeReg_reg[i] <= RST_VAL;
            end else if (wrEn && ptr_reg == OFS) begin
               modeReg_reg[i] <= wrMasked;
            end else if (puInit_reg && OFS == `VEM_OFS_POWERUP_PLL) begin
               modeReg_reg[i][`VEM_BIT_PU_SLEEP] <= ~(resetControlPin & standardPin);
            end
         end
      end
   endgenerate

   // ==========================================
   // decoded controls
   wire pal = mr2[`VEM_BIT_STD_SRC] ? programmedPal : standardPin;
   wire os4x = mr1[`VEM_BIT_OVERSAMPLE];
   wire bars = mr4[`VEM_BIT_BARS];
   wire [1:0] genlock = {mr4[`VEM_BIT_GL_HI], mr4[`VEM_BIT_GL_LO]};
   wire trMode = (genlock == 2'b10);
   wire scMode = (genlock == 2'b01);
   wire [1:0] uvSel = mr5[`VEM_UV_LSB +: 2];
   wire pinRise;
   logic rcPrev_reg;
   logic [1:0] trHold_reg;
   logic scPending_reg;
   logic pllNPrev_reg;

   assign pinRise = resetControlPin & ~rcPrev_reg;

   // in timing-reset genlock mode, pin high holds counters; hold is stretched to the minimum pulse width
   wire countersHeld = trMode && (resetControlPin || trHold_reg != 2'h0);
   wire [2:0] fieldMax = pal ? `VEM_FIELD_MAX_PAL : `VEM_FIELD_MAX_NTSC;

   vem_video_ctrl_s ctrlNext;

   always_comb begin
      ctrlNext = '0;
      ctrlNext.dacPowerDown = mr1[5:0];
      ctrlNext.dacRate4x = os4x;
      ctrlNext.dacRateMhz = os4x ? `VEM_RATE_4X_MHZ : `VEM_RATE_2X_MHZ;
      ctrlNext.pllEnable = ~mr6[`VEM_BIT_PLL_N];
      ctrlNext.dacSrc = dacRoute(mr2[`VEM_BIT_SCART], mr2[`VEM_BIT_GROUP], mr2[`VEM_BIT_YUV]);
      ctrlNext.pedestalEn = mr2[`VEM_BIT_PEDESTAL] & ~pal;
      ctrlNext.squarePixelEn = mr2[`VEM_BIT_SQUARE] & ~os4x;
      ctrlNext.palActive = pal;
      ctrlNext.pixelBlank = ~mr2[`VEM_BIT_PIXEL_VALID];
      ctrlNext.forceMaster = ~mr2[`VEM_BIT_PIXEL_VALID] | bars;
      ctrlNext.sleep = mr6[`VEM_BIT_PU_SLEEP] ? mr2[`VEM_BIT_SLEEP]
                       : (resetControlPin & standardPin);
      ctrlNext.teletextEn = mr3[`VEM_BIT_TTX_EN];
      ctrlNext.ttxRequest = mr3[`VEM_BIT_TTX_EN]
                            & (~mr3[`VEM_BIT_TTX_MODE] | ttxBitRequest);
      ctrlNext.vbiOpen = mr3[`VEM_BIT_VBI_OPEN];
      ctrlNext.ccField = mr3[`VEM_CC_LSB +: 2];
      ctrlNext.vsyncHalfLines = !mr4[`VEM_BIT_VSYNC3] ? 3'h0
                                : pal ? `VEM_VSYNC_PAL_HALF : `VEM_VSYNC_NTSC_HALF;
      ctrlNext.countersHeld = countersHeld;
      ctrlNext.rtcEnable = (genlock == 2'b11);
      ctrlNext.activePixels = !mr4[`VEM_BIT_ACTIVE_LINE] ? `VEM_PIX_601
                              : pal ? `VEM_PIX_PAL_470 : `VEM_PIX_NTSC_470;
      ctrlNext.chromaEn = mr4[`VEM_BIT_CHROMA];
      ctrlNext.burstEn = mr4[`VEM_BIT_BURST];
      ctrlNext.colourBars = bars;
      ctrlNext.syncOutEnN = bars;
      ctrlNext.interlaceOff = mr4[`VEM_BIT_INTERLACE];
      ctrlNext.ySmpte = mr5[`VEM_BIT_Y_LEVEL];
      case (uvSel)
         2'b01: ctrlNext.uvLevelMv = `VEM_UV_700;
         2'b10: ctrlNext.uvLevelMv = `VEM_UV_1000;
         default: ctrlNext.uvLevelMv = pal ? `VEM_UV_700 : `VEM_UV_NTSC_DEF;
      endcase
      ctrlNext.rgbSync = mr5[`VEM_BIT_RGB_SYNC];
      ctrlNext.clampDelay = mr5[`VEM_CLAMP_LSB +: 2];
      ctrlNext.clampNegative = mr5[`VEM_BIT_CLAMP_DIR];
      ctrlNext.clampBackPorch = mr5[`VEM_BIT_CLAMP_POS];
      ctrlNext.fieldCount = fieldCnt_reg;
   end

   // ==========================================
   // timing reset, subcarrier reset, field counter, pll reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rcPrev_reg <= 1'b0;
         trHold_reg <= 2'h0;
      end else begin
         rcPrev_reg <= resetControlPin;
         if (trMode && pinRise) begin
            trHold_reg <= 2'(`VEM_TR_MIN_CYC - 1);
         end else if (trHold_reg != 2'h0) begin
            trHold_reg <= trHold_reg - 2'h1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scPending_reg <= 1'b0;
         scPhaseReset <= 1'b0;
      end else begin
         scPhaseReset <= scPending_reg & fieldStart;
         scPending_reg <= (scMode & pinRise) | (scPending_reg & ~fieldStart);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fieldCnt_reg <= 3'h0;
      end else if (countersHeld) begin
         fieldCnt_reg <= 3'h0;
      end else if (fieldStart) begin
         fieldCnt_reg <= (fieldCnt_reg >= fieldMax) ? 3'h0 : fieldCnt_reg + 3'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pllNPrev_reg <= 1'b0;
         pllReset <= 1'b0;
      end else begin
         pllNPrev_reg <= mr6[`VEM_BIT_PLL_N];
         pllReset <= pllNPrev_reg ^ mr6[`VEM_BIT_PLL_N];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         videoCtrl <= '0;
      end else begin
         videoCtrl <= ctrlNext;
      end
   end

   assign sdaOut = sdaOut_reg;
   assign sdaOeN = sdaOeN_reg;

endmodule : vem_mode_regs

// ### vem_mode_regs_sva.sv
`include "vem_consts.svh"

module vem_mode_regs_sva
   import vem_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic scl,
   input wire logic sdaOeN,
   input wire logic ttxBitRequest,
   input wire logic fieldStart,
   input wire vem_video_ctrl_s videoCtrl,
   input wire logic pllReset,
   input wire logic scPhaseReset
);
   // =========================================
   // settle window: checks wait three edges after reset for outputs to follow registers
   logic [1:0] settleCnt;
   wire up = (settleCnt == 2'h3);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         settleCnt <= 2'h0;
      end else if (!up) begin
         settleCnt <= settleCnt + 2'h1;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // =========================================
   // properties
   chk_rate_mode: assert property (
      up |-> videoCtrl.dacRateMhz == (videoCtrl.dacRate4x ? `VEM_RATE_4X_MHZ : `VEM_RATE_2X_MHZ))
      else $error("dac rate does not match oversampling mode");
   chk_blank_master: assert property (
      up && videoCtrl.pixelBlank |-> videoCtrl.forceMaster)
      else $error("blanked pixels without master timing");
   chk_bars_release: assert property (
      up && videoCtrl.colourBars |-> videoCtrl.forceMaster && videoCtrl.syncOutEnN)
      else $error("colour bars without master timing or released sync pins");
   chk_pal_pedestal: assert property (
      videoCtrl.palActive |-> !videoCtrl.pedestalEn)
      else $error("pedestal active in pal");
   chk_line_width: assert property (
      up |-> videoCtrl.activePixels inside {`VEM_PIX_601, `VEM_PIX_NTSC_470, `VEM_PIX_PAL_470}
         && videoCtrl.activePixels != (videoCtrl.palActive ? `VEM_PIX_NTSC_470 : `VEM_PIX_PAL_470))
      else $error("wrong active pixel count");
   chk_pll_pulse: assert property (
      up && $changed(videoCtrl.pllEnable) |-> (pllReset || $past(pllReset)) or (##1 pllReset))
      else $error("pll enable changed without reset pulse");
   chk_pll_single: assert property (
      pllReset |=> !pllReset)
      else $error("pll reset pulse longer than one cycle");
   chk_phase_field: assert property (
      scPhaseReset |-> $past(fieldStart))
      else $error("subcarrier reset not at field start");
   chk_held_zero: assert property (
      videoCtrl.countersHeld |=> videoCtrl.fieldCount == 3'h0)
      else $error("field count moving while counters held");
   chk_sda_scl_low: assert property (
      $changed(sdaOeN) |-> !scl)
      else $error("data line changed while serial clock high");
   chk_ttx_bitwise: assert property (
      videoCtrl.teletextEn && $past(videoCtrl.teletextEn) && $past(ttxBitRequest)
         |-> videoCtrl.ttxRequest)
      else $error("teletext request missing");
endmodule : vem_mode_regs_sva

bind vem_mode_regs vem_mode_regs_sva chk (.clk, .rst, .scl, .sdaOeN, .ttxBitRequest,
   .fieldStart, .videoCtrl, .pllReset, .scPhaseReset);

// ### vem_host_model.sv
module vem_host_model (
   input wire logic clk,
   input wire logic sdaLine,
   output logic scl,
   output logic sdaDrv
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl = 1'b1;
      sdaDrv = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : tick
   // =========================================
   // bit level: data moves only while scl is low
   task automatic bitIo(input logic b, output logic r);
      tick(1);
      sdaDrv = b;
      tick(3);
      scl = 1'b1;
      tick(2);
      r = sdaLine;
      tick(2);
      scl = 1'b0;
   endtask : bitIo
   task automatic start();
      tick(1);
      sdaDrv = 1'b1;
      tick(3);
      scl = 1'b1;
      tick(4);
      sdaDrv = 1'b0;
      tick(4);
      scl = 1'b0;
   endtask : start
   task automatic stop();
      tick(1);
      sdaDrv = 1'b0;
      tick(3);
      scl = 1'b1;
      tick(4);
      sdaDrv = 1'b1;
      tick(4);
   endtask : stop
   task automatic txByte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitIo(d[i], r);
      end
      bitIo(1'b1, r);
      ack = !r;
   endtask : txByte
   task automatic rxByte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitIo(1'b1, d[i]);
      end
      bitIo(last, r);
   endtask : rxByte
endmodule : vem_host_model

// ### test_video_encoder_mode_registers.sv
`include "vem_consts.svh"

module test_video_encoder_mode_registers
   import vem_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic alsbPin = 1'b0;
   logic standardPin = 1'b0;
   logic resetControlPin = 1'b0;
   logic programmedPal = 1'b0;
   logic ttxBitRequest = 1'b0;
   logic fieldStart = 1'b0;
   logic scl;
   logic hostSda;
   logic sdaLine;
   logic sdaOut;
   logic sdaOeN;
   logic pllReset;
   logic scPhaseReset;
   vem_video_ctrl_s v;
   logic [6:0] devAddr = `VEM_SLAVE_ADDR & 7'h7d;
   int errCount = 0;
   int checksDone = 0;
   int pllPulses = 0;
   int scPulses = 0;

   always #12.5 clk = ~clk;
   // pull-up: line low only when some party pulls it
   assign sdaLine = hostSda & (sdaOeN | sdaOut);
   always @(posedge clk) begin
      pllPulses += pllReset;
      scPulses += scPhaseReset;
   end

   vem_mode_regs uut (.clk, .rst, .scl, .sdaIn(sdaLine), .sdaOut, .sdaOeN, .alsbPin,
      .standardPin, .resetControlPin, .programmedPal, .ttxBitRequest, .fieldStart,
      .videoCtrl(v), .pllReset, .scPhaseReset);
   vem_host_model host (.clk, .sdaLine, .scl, .sdaDrv(hostSda));

   // =========================================
   // shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         errCount++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic endOfTest();
      if (errCount == 0 && checksDone > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : endOfTest
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : step
   task automatic doReset();
      rst = 1'b1;
      step(8);
      rst = 1'b0;
      step(2);
   endtask : doReset
   task automatic wrBurst(input logic [6:0] sub, input logic [7:0] d[$], output int acks);
      logic a;
      acks = 0;
      host.start();
      host.txByte({devAddr, 1'b0}, a);
      acks += a;
      host.txByte({1'b0, sub}, a);
      acks += a;
      foreach (d[i]) begin
         host.txByte(d[i], a);
         acks += a;
      end
      host.stop();
   endtask : wrBurst
   task automatic wr(input logic [6:0] sub, input logic [7:0] d);
      int n;
      wrBurst(sub, '{d}, n);
      check(n, 3);
   endtask : wr
   task automatic rdBurst(input logic [6:0] sub, input int n, output logic [7:0] q[$]);
      logic a;
      logic [7:0] b;
      q = {};
      host.start();
      host.txByte({devAddr, 1'b0}, a);
      host.txByte({1'b0, sub}, a);
      host.start();
      host.txByte({devAddr, 1'b1}, a);
      for (int i = 0; i < n; i++) begin
         host.rxByte(i == n - 1, b);
         q.push_back(b);
      end
      host.stop();
   endtask : rdBurst
   task automatic rd(input logic [6:0] sub, input logic [7:0] exp);
      logic [7:0] q[$];
      rdBurst(sub, 1, q);
      check(q[0], exp);
   endtask : rd
   task automatic pulseFields(input int n);
      repeat (n) begin
         fieldStart = 1'b1;
         step(1);
         fieldStart = 1'b0;
         step(3);
      end
   endtask : pulseFields

   // =========================================
   // scenarios
   task automatic tReset();
      logic [7:0] q[$];
      rdBurst(7'h01, 6, q);
      check({q[0], q[1], q[2], q[3]}, 32'h0000_0000);
      check({q[4], q[5]}, 16'h0001);
      check({v.pixelBlank, v.forceMaster}, 2'h3);
      wr(7'h02, 8'h40);
      check({v.pixelBlank, v.forceMaster}, 2'h0);
   endtask : tReset
   task automatic tMasks();
      int n;
      int p;
      logic [7:0] q[$];
      p = pllPulses;
      wrBurst(7'h01, '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff}, n);
      check(n, 8);
      check(pllPulses - p, 1);
      rdBurst(7'h01, 7, q);
      check({q[0], q[1], q[2], q[3]}, 32'h7fff_7cff);
      check({q[4], q[5], q[6]}, 24'hff_0303);
      wrBurst(7'h06, '{8'h00, 8'h00}, n);
      check(n, 3);
      check(pllPulses - p, 2);
      wrBurst(7'h01, '{8'h00, 8'h40, 8'h00, 8'h00, 8'h00}, n);
      check(n, 7);
      wrBurst(7'h07, '{8'h00}, n);
      check(n, 1);
      alsbPin = 1'b1;
      wrBurst(7'h02, '{8'h40}, n);
      check(n, 0);
      devAddr = `VEM_SLAVE_ADDR | 7'h02;
      wr(7'h02, 8'h40);
   endtask : tMasks
   task automatic tRouting();
      vem_dac_src_e c[3];
      vem_dac_src_e e[6];
      for (int k = 0; k < 8; k++) begin
         wr(7'h02, 8'h40 | 8'(k));
         c = '{VEM_SRC_G, VEM_SRC_B, VEM_SRC_R};
         if (k[0]) begin
            c = '{VEM_SRC_Y, VEM_SRC_U, VEM_SRC_V};
         end
         e = '{VEM_SRC_CVBS, c[1], c[2], c[0], VEM_SRC_LUMA, VEM_SRC_CHROMA};
         if (k[1]) begin
            e = '{VEM_SRC_CVBS, VEM_SRC_LUMA, VEM_SRC_CHROMA, c[0], c[1], c[2]};
         end else if (!k[2]) begin
            e = '{c[0], c[1], c[2], VEM_SRC_CVBS, VEM_SRC_LUMA, VEM_SRC_CHROMA};
         end
         for (int i = 0; i < 6; i++) begin
            check(v.dacSrc[i], e[i]);
         end
      end
   endtask : tRouting
   task automatic tStandard();
      logic pal;
      wr(7'h04, 8'h09);
      wr(7'h05, 8'h00);
      for (int s = 0; s < 8; s++) begin
         {programmedPal, standardPin} = 2'(s);
         wr(7'h02, 8'h58 | (8'(s[2]) << 5));
         pal = s[2] ? s[1] : s[0];
         check(v.palActive, pal);
         check({v.pedestalEn, v.squarePixelEn}, {!pal, 1'b1});
         check(v.activePixels, pal ? `VEM_PIX_PAL_470 : `VEM_PIX_NTSC_470);
         check(v.uvLevelMv, pal ? `VEM_UV_700 : `VEM_UV_NTSC_DEF);
         check(v.vsyncHalfLines, pal ? `VEM_VSYNC_PAL_HALF : `VEM_VSYNC_NTSC_HALF);
      end
      wr(7'h05, 8'h04);
      check(v.uvLevelMv, `VEM_UV_1000);
      wr(7'h05, 8'h02);
      check(v.uvLevelMv, `VEM_UV_700);
      wr(7'h04, 8'h00);
      check({v.activePixels, v.vsyncHalfLines}, {`VEM_PIX_601, 3'h0});
   endtask : tStandard
   task automatic tControls();
      wr(7'h04, 8'h40);
      check({v.colourBars, v.forceMaster, v.syncOutEnN}, 3'h7);
      wr(7'h04, 8'h00);
      check(v.syncOutEnN, 1'b0);
      wr(7'h05, 8'hb0);
      check({v.clampBackPorch, v.clampNegative, v.clampDelay}, 4'hb);
      wr(7'h05, 8'h60);
      check({v.clampBackPorch, v.clampNegative, v.clampDelay}, 4'h6);
      wr(7'h01, 8'h6a);
      check({v.dacRate4x, v.dacRateMhz, v.dacPowerDown}, {1'b1, `VEM_RATE_4X_MHZ, 6'h2a});
      check(v.squarePixelEn, 1'b0);
      wr(7'h01, 8'h15);
      check({v.dacRate4x, v.dacRateMhz, v.dacPowerDown}, {1'b0, `VEM_RATE_2X_MHZ, 6'h15});
      wr(7'h03, 8'h08);
      check(v.ttxRequest, 1'b1);
      wr(7'h03, 8'h18);
      check(v.ttxRequest, 1'b0);
      ttxBitRequest = 1'b1;
      step(2);
      check(v.ttxRequest, 1'b1);
      ttxBitRequest = 1'b0;
      wr(7'h03, 8'h00);
   endtask : tControls
   task automatic tGenlock();
      int p;
      {programmedPal, standardPin} = 2'h0;
      wr(7'h02, 8'h40);
      pulseFields(5);
      rd(7'h06, 8'h20);
      standardPin = 1'b1;
      pulseFields(9);
      rd(7'h06, 8'h40);
      wr(7'h04, 8'h04);
      resetControlPin = 1'b1;
      step(4);
      check({v.countersHeld, v.fieldCount}, 4'h8);
      pulseFields(1);
      check(v.fieldCount, 3'h0);
      resetControlPin = 1'b0;
      step(4);
      check(v.countersHeld, 1'b0);
      wr(7'h04, 8'h02);
      p = scPulses;
      resetControlPin = 1'b1;
      step(4);
      check(scPulses - p, 0);
      pulseFields(2);
      check(scPulses - p, 1);
      wr(7'h04, 8'h06);
      check(v.rtcEnable, 1'b1);
      wr(7'h04, 8'h00);
      check(v.countersHeld, 1'b0);
      resetControlPin = 1'b0;
   endtask : tGenlock
   task automatic tSleep();
      {resetControlPin, standardPin} = 2'h3;
      doReset();
      rd(7'h06, 8'h00);
      check(v.sleep, 1'b1);
      wr(7'h06, 8'h01);
      check(v.sleep, 1'b0);
      wr(7'h02, 8'h80);
      check(v.sleep, 1'b1);
      rd(7'h02, 8'h80);
      wr(7'h02, 8'h00);
      check(v.sleep, 1'b0);
      wr(7'h02, 8'h80);
      resetControlPin = 1'b0;
      doReset();
      check(v.sleep, 1'b0);
      rd(7'h02, 8'h00);
   endtask : tSleep

   initial begin
      repeat (100000) @(posedge clk);
      errCount++;
      endOfTest();
   end
   initial begin
      doReset();
      tReset();
      tMasks();
      tRouting();
      tStandard();
      tControls();
      tGenlock();
      tSleep();
      endOfTest();
   end
endmodule : test_video_encoder_mode_registers
